/* File: hdl/sfrot_defs.vh */
// constants for the set-register / rotate-right execution block
// included by hdl/sfrot_exec.v only
`ifndef SFROT_DEFS_VH
`define SFROT_DEFS_VH
// opcode fields of the 16-bit instruction word
`define SFROT_SET_OPC 7'h34
`define SFROT_SET_OPC_HI 15
`define SFROT_SET_OPC_LO 9
`define SFROT_ROT_OPC 6'h10
`define SFROT_ROT_OPC_HI 15
`define SFROT_ROT_OPC_LO 10
`define SFROT_D_BIT 9
`define SFROT_A_BIT 8
`define SFROT_F_HI 7
`define SFROT_F_LO 0
// values and limits
`define SFROT_ALL_ONES 8'hff
`define SFROT_ZERO_BYTE 8'h00
`define SFROT_IDX_LIMIT 8'h5f
`define SFROT_ACC_SPLIT 8'h80
`define SFROT_ACC_HI_BANK 4'hf
`define SFROT_ACC_LO_BANK 4'h0
`define SFROT_ADDR_ZERO 12'h000
`define SFROT_BANK_ZERO 4'h0
// quarter phase one-hot codes
`define SFROT_Q1 4'h1
`define SFROT_Q2 4'h2
`define SFROT_Q3 4'h4
`define SFROT_Q4 4'h8
`endif

/* File: hdl/sfrot_exec.v */
// execution tail for the set-register and rotate-right-no-carry ops
// assumes: the decoder outside issues one instruction per
// four-clock cycle of the internal quarter-phase counter; data memory reads combinationally on o_mem_addr
// How it works
// - set-register op writes 8'hff into the addressed file register
// - access bit zero, when not indexed, targets the access bank, bank select ignored
// - access bit one takes the bank from the bank-select register
// - access bit zero, extended set on, f up to 5f is indexed offset
// - rotate with destination one writes result back to file register
// - rotate with destination zero writes working register, file kept
// - rotate right one place, bit 0 into bit 7, carry untouched
`timescale 1ns/1ns
`include "sfrot_defs.vh"
module sfrot_exec (
   // clock and reset
   input wire I_CLK,
   input wire I_RESETN,
   input wire I_CE,
   // instruction from decoder, held for the whole instruction cycle
   input wire I_VALID,
   input wire [15:0] I_INSTR,
   // core state
   input wire [3:0] I_BANK_SELECT_REGISTER,
   input wire [11:0] I_INDEX_BASE,
   input wire I_EXT_SET_EN,
   // data memory
   input wire [7:0] I_MEM_RDATA,
   output reg [11:0] O_MEM_ADDR,
   output reg [7:0] O_MEM_WDATA,
   output reg O_MEM_WE,
   // working register and status side
   output reg [7:0] O_W_DATA,
   output reg O_W_WE,
   output reg O_NZ_UPDATE,
   output reg O_BUSY
);
   localparam ST_Q1 = `SFROT_Q1;
   localparam ST_Q2 = `SFROT_Q2;
   localparam ST_Q3 = `SFROT_Q3;
   localparam ST_Q4 = `SFROT_Q4;

   // quarter phase state
   reg [3:0] st_q;
   reg [3:0] st_d;
   // operation latched in the decode phase
   reg is_set_q;
   reg is_set_d;
   reg is_rot_q;
   reg is_rot_d;
   reg dest_q;
   reg dest_d;
   // result byte
   reg [7:0] res_q;
   reg [7:0] res_d;
   // next values of the registered outputs
   reg [11:0] mem_addr_d;
   reg [7:0] mem_wdata_d;
   reg mem_we_d;
   reg [7:0] w_data_d;
   reg w_we_d;
   reg nz_upd_d;
   reg busy_d;

   // phase decode
   wire in_q1 = (st_q == ST_Q1);
   wire in_q3 = (st_q == ST_Q3);
   wire in_q4 = (st_q == ST_Q4);

   // instruction fields
   wire [7:0] f_fld = I_INSTR[`SFROT_F_HI:`SFROT_F_LO];
   wire a_bit = I_INSTR[`SFROT_A_BIT];
   wire d_bit = I_INSTR[`SFROT_D_BIT];
   wire [6:0] set_opc = I_INSTR[`SFROT_SET_OPC_HI:`SFROT_SET_OPC_LO];
   wire [5:0] rot_opc = I_INSTR[`SFROT_ROT_OPC_HI:`SFROT_ROT_OPC_LO];
   wire dec_set = I_VALID && (set_opc == `SFROT_SET_OPC);
   wire dec_rot = I_VALID && (rot_opc == `SFROT_ROT_OPC);
   wire dec_any = dec_set | dec_rot;
   // base plus offset wraps inside the 12-bit data space
   wire [11:0] idx_sum = I_INDEX_BASE + {`SFROT_BANK_ZERO, f_fld};
   wire idx_range = (f_fld <= `SFROT_IDX_LIMIT);
   wire lo_access = (f_fld < `SFROT_ACC_SPLIT);
   reg [11:0] eff_addr;

   always @* begin
      if (a_bit) begin
         eff_addr = {I_BANK_SELECT_REGISTER, f_fld};
      end else if (I_EXT_SET_EN && idx_range) begin
         eff_addr = idx_sum;
      end else if (lo_access) begin
         eff_addr = {`SFROT_ACC_LO_BANK, f_fld};
      end else begin
         eff_addr = {`SFROT_ACC_HI_BANK, f_fld};
      end
   end

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_Q1: st_d = ST_Q2;
         ST_Q2: st_d = ST_Q3;
         ST_Q3: st_d = ST_Q4;
         ST_Q4: st_d = ST_Q1;
         default: st_d = ST_Q1;
      endcase
   end

   // instruction word is ignored outside the decode phase
   always @* begin
      is_set_d = is_set_q;
      is_rot_d = is_rot_q;
      dest_d = dest_q;
      if (in_q1) begin
         is_set_d = dec_set;
         is_rot_d = dec_rot;
         dest_d = d_bit;
      end
   end

   always @* begin
      res_d = res_q;
      if (in_q3) begin
         if (is_set_q) begin
            res_d = `SFROT_ALL_ONES;
         end else begin
            // carry is neither read nor written here
            res_d = {I_MEM_RDATA[0], I_MEM_RDATA[7:1]};
         end
      end
   end

   always @* begin
      mem_addr_d = O_MEM_ADDR;
      if (in_q1) begin
         mem_addr_d = eff_addr;
      end
   end

   // data outputs hold the last result between operations
   always @* begin
      mem_wdata_d = O_MEM_WDATA;
      w_data_d = O_W_DATA;
      if (in_q3 && (is_set_q || is_rot_q)) begin
         mem_wdata_d = res_d;
         w_data_d = res_d;
      end
   end

   // one write in the last phase, then done: single cycle, one word
   always @* begin
      mem_we_d = 1'b0;
      w_we_d = 1'b0;
      nz_upd_d = 1'b0;
      if (in_q3) begin
         mem_we_d = is_set_q | (is_rot_q & dest_q);
         w_we_d = is_rot_q & ~dest_q;
         // set-register leaves status alone
         nz_upd_d = is_rot_q;
      end
   end

   always @* begin
      busy_d = O_BUSY;
      if (in_q1) begin
         busy_d = dec_any;
      end else if (in_q4) begin
         busy_d = 1'b0;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         st_q <= ST_Q1;
      end else if (I_CE) begin
         st_q <= st_d;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         is_set_q <= 1'b0;
         is_rot_q <= 1'b0;
         dest_q <= 1'b0;
      end else if (I_CE) begin
         is_set_q <= is_set_d;
         is_rot_q <= is_rot_d;
         dest_q <= dest_d;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         res_q <= `SFROT_ZERO_BYTE;
      end else if (I_CE) begin
         res_q <= res_d;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_MEM_ADDR <= `SFROT_ADDR_ZERO;
      end else if (I_CE) begin
         O_MEM_ADDR <= mem_addr_d;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_MEM_WDATA <= `SFROT_ZERO_BYTE;
         O_W_DATA <= `SFROT_ZERO_BYTE;
      end else if (I_CE) begin
         O_MEM_WDATA <= mem_wdata_d;
         O_W_DATA <= w_data_d;
      end
   end

   // a frozen clock enable stretches the strobes with everything else
   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_MEM_WE <= 1'b0;
         O_W_WE <= 1'b0;
         O_NZ_UPDATE <= 1'b0;
      end else if (I_CE) begin
         O_MEM_WE <= mem_we_d;
         O_W_WE <= w_we_d;
         O_NZ_UPDATE <= nz_upd_d;
      end
   end

   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_BUSY <= 1'b0;
      end else if (I_CE) begin
         O_BUSY <= busy_d;
      end
   end
endmodule

/* File: test/sfrot_checker.sv */
// port checker for sfrot_exec
// assumes clock enable is low only outside the write phase
`timescale 1ns/1ns
module sfrot_checker (
   input wire I_CLK, input wire I_RESETN, input wire I_EXT_SET_EN,
   input wire [15:0] I_INSTR, input wire [3:0] I_BANK_SELECT_REGISTER,
   input wire [11:0] I_INDEX_BASE, input wire [7:0] I_MEM_RDATA,
   input wire [11:0] O_MEM_ADDR, input wire [7:0] O_MEM_WDATA,
   input wire [7:0] O_W_DATA, input wire O_MEM_WE, input wire O_W_WE,
   input wire O_NZ_UPDATE, input wire O_BUSY
);
   wire [7:0] f = I_INSTR[7:0];
   wire [7:0] rot = {I_MEM_RDATA[0], I_MEM_RDATA[7:1]};
   wire lo = !I_INSTR[8] && !I_EXT_SET_EN && !f[7];
   wire ix = !I_INSTR[8] && I_EXT_SET_EN && f <= 8'h5f;
   wire hi = !I_INSTR[8] && f[7];
   wire [11:0] ex = I_INDEX_BASE + f;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_wr;
      O_MEM_WE ##1 !O_MEM_WE;
   endsequence
   a_set_ones: assert property (O_MEM_WE && !O_NZ_UPDATE |->
      O_MEM_WDATA == 8'hff) else $error("set data");
   a_rot_val: assert property (O_NZ_UPDATE |->
      (O_W_WE ? O_W_DATA : O_MEM_WDATA) == $past(rot)) else $error("rot");
   a_one_dest: assert property (!(O_MEM_WE && O_W_WE))
      else $error("two writes");
   a_pulse_one: assert property ($rose(O_MEM_WE) |-> s_wr)
      else $error("long pulse");
   a_busy_end: assert property (O_MEM_WE || O_W_WE |-> ##1 !O_BUSY)
      else $error("busy");
   a_bank_sel: assert property ($rose(O_BUSY) && $past(I_INSTR[8]) |->
      O_MEM_ADDR == {$past(I_BANK_SELECT_REGISTER), $past(f)})
      else $error("bsr");
   a_acc_low: assert property ($rose(O_BUSY) && $past(lo) |->
      O_MEM_ADDR == {4'h0, $past(f)}) else $error("access");
   a_acc_high: assert property ($rose(O_BUSY) && $past(hi) |->
      O_MEM_ADDR == {4'hf, $past(f)}) else $error("access high");
   a_idx_addr: assert property ($rose(O_BUSY) && $past(ix) |->
      O_MEM_ADDR == $past(ex)) else $error("indexed");
endmodule

/* File: test/sfrot_exec_tb.sv */
// bench for sfrot_exec: fixed ops, expected address and data
// assumes first edge after reset release is a decode phase
`timescale 1ns/1ns
module sfrot_exec_tb;
   reg I_CLK = 0, I_RESETN = 0, I_CE = 1, I_VALID = 1, I_EXT_SET_EN = 0;
   reg [15:0] I_INSTR = 16'h0000;
   reg [3:0] I_BANK_SELECT_REGISTER = 4'h0;
   reg [11:0] I_INDEX_BASE = 12'h200;
   reg [7:0] I_MEM_RDATA = 8'h00;
   wire [11:0] O_MEM_ADDR;
   wire [7:0] O_MEM_WDATA, O_W_DATA;
   wire O_MEM_WE, O_W_WE, O_NZ_UPDATE, O_BUSY;
   integer n_mismatch = 0, samples_checked = 0, cyc = 0;
   sfrot_exec uut (
      .I_CLK(I_CLK),
      .I_RESETN(I_RESETN),
      .I_CE(I_CE),
      .I_VALID(I_VALID),
      .I_INSTR(I_INSTR),
      .I_BANK_SELECT_REGISTER(I_BANK_SELECT_REGISTER),
      .I_INDEX_BASE(I_INDEX_BASE),
      .I_EXT_SET_EN(I_EXT_SET_EN),
      .I_MEM_RDATA(I_MEM_RDATA),
      .O_MEM_ADDR(O_MEM_ADDR),
      .O_MEM_WDATA(O_MEM_WDATA),
      .O_MEM_WE(O_MEM_WE),
      .O_W_DATA(O_W_DATA),
      .O_W_WE(O_W_WE),
      .O_NZ_UPDATE(O_NZ_UPDATE),
      .O_BUSY(O_BUSY)
   );
   task chk(input [11:0] got, input [11:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: %h %h", $time, got, exp);
         end
      end
   endtask
   task op(input [15:0] in, input [3:0] b, input e, input [7:0] rd,
      input [11:0] ea, input mw, input [7:0] ed);
      begin
         I_INSTR = in;
         I_BANK_SELECT_REGISTER = b;
         I_EXT_SET_EN = e;
         @(posedge I_CLK) #1;
         chk(O_MEM_ADDR, ea);
         chk(O_BUSY, 12'h001);
         I_MEM_RDATA = rd;
         repeat (2) @(posedge I_CLK);
         #1;
         chk(O_MEM_WE, mw);
         chk(O_W_WE, !mw);
         chk(O_NZ_UPDATE, in[15:10] == 6'h10);
         chk(mw ? O_MEM_WDATA : O_W_DATA, ed);
         @(posedge I_CLK) #1;
         chk({O_MEM_WE, O_W_WE, O_BUSY}, 12'h000);
         $display("test %h done", in);
      end
   endtask
   task t_set_bank;
      op(16'h6912, 4'h3, 1'h0, 8'h00, 12'h312, 1'h1, 8'hff);
   endtask
   task t_set_access;
      op(16'h6840, 4'h3, 1'h0, 8'h00, 12'h040, 1'h1, 8'hff);
   endtask
   task t_set_indexed;
      op(16'h685f, 4'h3, 1'h1, 8'h00, 12'h25f, 1'h1, 8'hff);
   endtask
   task t_set_past_limit;
      op(16'h6860, 4'h3, 1'h1, 8'h00, 12'h060, 1'h1, 8'hff);
   endtask
   task t_rot_file;
      op(16'h4320, 4'h1, 1'h0, 8'hd7, 12'h120, 1'h1, 8'heb);
   endtask
   task t_rot_w;
      op(16'h40a5, 4'h1, 1'h1, 8'hd7, 12'hfa5, 1'h0, 8'heb);
   endtask
   task t_refused;
      begin
         I_INSTR = 16'h1234;
         repeat (4) begin
            @(posedge I_CLK) #1;
            chk({O_MEM_WE, O_W_WE, O_BUSY}, 12'h000);
         end
         I_INSTR = 16'h69ff;
         I_VALID = 0;
         repeat (4) begin
            @(posedge I_CLK) #1;
            chk({O_MEM_WE, O_W_WE, O_BUSY}, 12'h000);
         end
         I_VALID = 1;
         $display("test refused done");
      end
   endtask
   task t_ce_freeze;
      begin
         I_INSTR = 16'h6977;
         I_BANK_SELECT_REGISTER = 4'h5;
         I_EXT_SET_EN = 0;
         @(posedge I_CLK) #1;
         chk(O_MEM_ADDR, 12'h577);
         I_CE = 0;
         repeat (3) begin
            @(posedge I_CLK) #1;
            chk({O_MEM_WE, O_BUSY}, 12'h001);
         end
         I_CE = 1;
         repeat (2) @(posedge I_CLK);
         #1;
         chk({O_MEM_WE, O_MEM_WDATA}, 12'h1ff);
         @(posedge I_CLK) #1;
         chk(O_MEM_WE, 12'h000);
         $display("test freeze done");
      end
   endtask
   task t_mid_reset;
      begin
         I_INSTR = 16'h4320;
         I_BANK_SELECT_REGISTER = 4'h1;
         repeat (2) @(posedge I_CLK);
         #1;
         I_RESETN = 0;
         #1;
         chk({O_MEM_WE, O_W_WE, O_BUSY}, 12'h000);
         chk(O_MEM_ADDR, 12'h000);
         @(posedge I_CLK) #1;
         I_RESETN = 1;
         $display("test reset done");
      end
   endtask
   task results;
      begin
         $display("checked %0d wrong %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   always @(posedge I_CLK) begin
      cyc = cyc + 1;
      if (cyc == 500) begin
         n_mismatch = n_mismatch + 1;
         results;
      end
   end
   initial forever #4 I_CLK = ~I_CLK;
   initial begin
      repeat (2) @(posedge I_CLK);
      #1;
      I_RESETN = 1;
      t_set_bank;
      t_set_access;
      t_set_indexed;
      t_set_past_limit;
      t_rot_file;
      t_rot_w;
      t_refused;
      t_ce_freeze;
      t_mid_reset;
      t_rot_file;
      results;
   end
endmodule
bind sfrot_exec sfrot_checker chk_i (.*);
